// ==== core/vrpf_defines.svh ====
`ifndef VRPF_DEFINES_SVH
`define VRPF_DEFINES_SVH

// Controller clock rate and power-monitor pulse rate.
`define VRPF_CLK_MHZ 100
`define VRPF_POWER_MONITOR_OUT_FREQ_KHZ 300
// Longest period that stays at or above the nominal rate, so it rounds down.
`define VRPF_POWER_MONITOR_OUT_CYC ((`VRPF_CLK_MHZ * 1000) / `VRPF_POWER_MONITOR_OUT_FREQ_KHZ)
`define VRPF_POWER_MONITOR_OUT_CNT_W 9
`define VRPF_DUTY_W 8

// Target voltage in units of 100 uV.
`define VRPF_VID_W 7
`define VRPF_TARGET_W 16
`define VRPF_VID_BASE 16'h3A98
`define VRPF_VID_STEP 16'h007D
`define VRPF_VID_ZERO_FROM 7'h78
`define VRPF_TARGET_RST 16'h0000

// Comparator flag bundle positions.
`define VRPF_CMP_W 7
`define VRPF_CMP_OV 0
`define VRPF_CMP_RV_BELOW 1
`define VRPF_CMP_RV_ABOVE 2
`define VRPF_CMP_SUPPLY_OK 3
`define VRPF_CMP_TT_GROUND 4
`define VRPF_CMP_TT_TRIP 5
`define VRPF_CMP_TT_RELEASE 6

`define VRPF_PHASES 3
`define VRPF_BIT_RST 1'b0

`endif

// ==== core/vrpf_pkg.sv ====
`include "vrpf_defines.svh"

package vrpf_pkg;

	typedef enum logic [2:0] {
		vrpf_st_shutdown = 3'h1,
		vrpf_st_run = 3'h2,
		vrpf_st_latched = 3'h4
	} vrpf_state_t;

	typedef logic [`VRPF_VID_W-1:0] vrpf_code_t;
	typedef logic [`VRPF_TARGET_W-1:0] vrpf_target_t;
	typedef logic [`VRPF_DUTY_W-1:0] vrpf_duty_t;
	typedef logic [`VRPF_POWER_MONITOR_OUT_CNT_W-1:0] vrpf_power_monitor_out_cnt_t;

endpackage

// ==== core/vrpf_mon_if.sv ====
`timescale 1ns/1ps

interface vrpf_mon_if;
	import vrpf_pkg::*;

	logic run;
	vrpf_duty_t duty;
	logic pwm;

	modport ctrl (output run, output duty, input pwm);
	modport gen (input run, input duty, output pwm);
endinterface

// ==== core/vrpf_sync.sv ====
`timescale 1ns/1ps

module vrpf_sync #(
	parameter int W = 1
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;

	// The first stage feeds only the second, so metastability cannot leak out.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
		end
	end

	assign sync_out = stage2;
endmodule

// ==== core/vrpf_power_monitor_out.sv ====
`timescale 1ns/1ps
`include "vrpf_defines.svh"

module vrpf_power_monitor_out
	import vrpf_pkg::*;
(
	input wire logic clock_in,
	input wire logic arst_n_in,
	vrpf_mon_if.gen mon
);
	localparam vrpf_power_monitor_out_cnt_t PERIOD = `VRPF_POWER_MONITOR_OUT_CNT_W'(`VRPF_POWER_MONITOR_OUT_CYC);

	vrpf_power_monitor_out_cnt_t count;
	vrpf_power_monitor_out_cnt_t next_count;
	vrpf_power_monitor_out_cnt_t thresh;
	vrpf_power_monitor_out_cnt_t next_thresh;
	logic level;
	logic next_level;
	logic period_start;
	logic [`VRPF_DUTY_W+`VRPF_POWER_MONITOR_OUT_CNT_W-1:0] product;

	// Duty is sampled once per period so a pulse is cut short mid-cycle only when run drops.
	always_comb begin
		period_start = (count == PERIOD - 9'h001);
		next_count = period_start ? 9'h000 : count + 9'h001;
		product = mon.duty * PERIOD;
		next_thresh = period_start ? product[16:8] : thresh;
		next_level = mon.run && (next_count < next_thresh);
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count <= 9'h000;
			thresh <= 9'h000;
			level <= `VRPF_BIT_RST;
		end else begin
			count <= next_count;
			thresh <= next_thresh;
			level <= next_level;
		end
	end

	assign mon.pwm = level;
endmodule

// ==== core/vrpf_top.sv ====
`timescale 1ns/1ps
`include "vrpf_defines.svh"


module vrpf_top
	import vrpf_pkg::*;
(
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic enable_in,
	input wire logic overvoltage_cmp_in,
	input wire logic reverse_below_cmp_in,
	input wire logic reverse_above_cmp_in,
	input wire logic supply_ok_cmp_in,
	input wire logic thermal_grounded_cmp_in,
	input wire logic thermal_trip_cmp_in,
	input wire logic thermal_release_cmp_in,
	input wire logic [`VRPF_PHASES-1:0] phase_pwm_req_in,
	input wire logic [`VRPF_DUTY_W-1:0] inductor_current_in,
	input wire logic [`VRPF_VID_W-1:0] voltage_select_code_in,
	output logic [`VRPF_PHASES-1:0] phase_pwm_out,
	output logic lowside_mode_ctl_out,
	output logic driver_enable_out,
	output logic softstart_discharge_out,
	output logic thermal_throttle_alarm_out,
	output logic power_monitor_out,
	output logic [`VRPF_TARGET_W-1:0] voltage_target_out,
	output logic overvoltage_guard_latched_out,
	output logic reverse_voltage_guard_out,
	output logic switching_out
);

	logic [`VRPF_CMP_W-1:0] cmp_raw;
	logic [`VRPF_CMP_W-1:0] cmp;
	logic ov_seen;
	logic rv_below;
	logic rv_above;
	logic supply_ok;
	logic tt_ground;
	logic tt_trip;
	logic tt_release;

	vrpf_state_t state;
	vrpf_state_t next_state;
	logic rv_active;
	logic next_rv_active;
	logic alarm;
	logic next_alarm;

	logic [`VRPF_PHASES-1:0] pwm;
	logic [`VRPF_PHASES-1:0] next_pwm;
	logic lowside;
	logic next_lowside;
	logic drv_en;
	logic next_drv_en;
	logic ss_dis;
	logic next_ss_dis;
	logic latched;
	logic next_latched;
	logic running;
	logic next_running;
	logic may_switch;
	logic ov_trip;

	vrpf_target_t target;
	vrpf_target_t next_target;
	vrpf_duty_t duty;
	vrpf_duty_t next_duty;

	vrpf_mon_if mon ();

	// Comparator flags arrive from analog blocks with no relation to the clock.
	always_comb begin
		cmp_raw = '0;
		cmp_raw[`VRPF_CMP_OV] = overvoltage_cmp_in;
		cmp_raw[`VRPF_CMP_RV_BELOW] = reverse_below_cmp_in;
		cmp_raw[`VRPF_CMP_RV_ABOVE] = reverse_above_cmp_in;
		cmp_raw[`VRPF_CMP_SUPPLY_OK] = supply_ok_cmp_in;
		cmp_raw[`VRPF_CMP_TT_GROUND] = thermal_grounded_cmp_in;
		cmp_raw[`VRPF_CMP_TT_TRIP] = thermal_trip_cmp_in;
		cmp_raw[`VRPF_CMP_TT_RELEASE] = thermal_release_cmp_in;
	end

	vrpf_sync #(
		.W(`VRPF_CMP_W)
	) u_sync (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.async_in(cmp_raw),
		.sync_out(cmp)
	);

	assign ov_seen = cmp[`VRPF_CMP_OV];
	assign rv_below = cmp[`VRPF_CMP_RV_BELOW];
	assign rv_above = cmp[`VRPF_CMP_RV_ABOVE];
	assign supply_ok = cmp[`VRPF_CMP_SUPPLY_OK];
	assign tt_ground = cmp[`VRPF_CMP_TT_GROUND];
	assign tt_trip = cmp[`VRPF_CMP_TT_TRIP];
	assign tt_release = cmp[`VRPF_CMP_TT_RELEASE];

	// Main protection sequence.
	always_comb begin
		may_switch = supply_ok && enable_in;
		// The flag compares the sense reference node against the crowbar level.
		ov_trip = ov_seen && !tt_ground;
		next_state = state;
		case (state)
			vrpf_st_shutdown: begin
				if (may_switch) begin
					next_state = vrpf_st_run;
				end
			end
			vrpf_st_run: begin
				if (!may_switch) begin
					next_state = vrpf_st_shutdown;
				end else if (ov_trip) begin
					next_state = vrpf_st_latched;
				end
			end
			vrpf_st_latched: begin
				// Only a lockout or an enable low phase clears the latch.
				if (!may_switch) begin
					next_state = vrpf_st_shutdown;
				end
			end
			default: begin
				next_state = vrpf_st_shutdown;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= vrpf_st_shutdown;
		end else begin
			state <= next_state;
		end
	end

	// Reverse guard with separate entry and exit levels.
	always_comb begin
		next_rv_active = rv_active;
		if (rv_below) begin
			next_rv_active = 1'b1;
		end else if (rv_above) begin
			next_rv_active = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rv_active <= `VRPF_BIT_RST;
		end else begin
			rv_active <= next_rv_active;
		end
	end

	// Thermal alarm: trip and release are the two hysteresis edges of the comparator.
	always_comb begin
		next_alarm = alarm;
		if (tt_trip) begin
			next_alarm = 1'b1;
		end else if (tt_release) begin
			next_alarm = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			alarm <= `VRPF_BIT_RST;
		end else begin
			alarm <= next_alarm;
		end
	end

	// Driver lines follow the next state so they change with it, not a cycle later.
	always_comb begin
		next_pwm = '0;
		next_lowside = 1'b0;
		next_drv_en = 1'b0;
		next_ss_dis = 1'b0;
		next_latched = 1'b0;
		next_running = 1'b0;
		case (next_state)
			vrpf_st_shutdown: begin
				next_ss_dis = 1'b1;
			end
			vrpf_st_run: begin
				next_running = 1'b1;
				if (!next_rv_active) begin
					next_pwm = phase_pwm_req_in;
					next_lowside = 1'b1;
					next_drv_en = 1'b1;
				end
				// A reverse condition leaves every switch off.
			end
			vrpf_st_latched: begin
				next_latched = 1'b1;
				// Crowbar holds low sides on unless reverse voltage says release.
				next_lowside = !next_rv_active;
				next_drv_en = !next_rv_active;
			end
			default: begin
				next_ss_dis = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pwm <= '0;
			lowside <= `VRPF_BIT_RST;
			drv_en <= `VRPF_BIT_RST;
			ss_dis <= 1'b1;
			latched <= `VRPF_BIT_RST;
			running <= `VRPF_BIT_RST;
		end else begin
			pwm <= next_pwm;
			lowside <= next_lowside;
			drv_en <= next_drv_en;
			ss_dis <= next_ss_dis;
			latched <= next_latched;
			running <= next_running;
		end
	end

	// Select code decode; the top eight codes all mean zero volts.
	always_comb begin
		if (voltage_select_code_in >= `VRPF_VID_ZERO_FROM) begin
			next_target = `VRPF_TARGET_RST;
		end else begin
			next_target = `VRPF_VID_BASE - `VRPF_TARGET_W'(voltage_select_code_in * `VRPF_VID_STEP);
		end
		next_duty = inductor_current_in;
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			target <= `VRPF_TARGET_RST;
			duty <= '0;
		end else begin
			target <= next_target;
			duty <= next_duty;
		end
	end

	// Amplitude scaling to twice the sense reference is done by the analog output stage.
	assign mon.run = running && !rv_active;
	assign mon.duty = duty;

	vrpf_power_monitor_out u_power_monitor_out (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.mon(mon)
	);

	assign phase_pwm_out = pwm;
	assign lowside_mode_ctl_out = lowside;
	assign driver_enable_out = drv_en;
	assign softstart_discharge_out = ss_dis;
	assign thermal_throttle_alarm_out = alarm;
	assign power_monitor_out = mon.pwm;
	assign voltage_target_out = target;
	assign overvoltage_guard_latched_out = latched;
	assign reverse_voltage_guard_out = rv_active;
	assign switching_out = running;

endmodule

// ==== tb/vrpf_supply_model.sv ====
`timescale 1ns/1ps

// Comparators of the sensed core rail, the thermal divider and the supply, all in mV.
module vrpf_supply_model #(
	parameter int LOCKOUT_MV = 4000,
	parameter int GROUND_MV = 100
) (
	input int sense_mv_in,
	input int tt_mv_in,
	input int vcc_mv_in,
	output logic ov_out,
	output logic rv_below_out,
	output logic rv_above_out,
	output logic supply_ok_out,
	output logic tt_gnd_out,
	output logic tt_trip_out,
	output logic tt_release_out
);
	// The band sits evenly around half supply, so trip and release are about 100 mV apart.
	always_comb begin
		ov_out = sense_mv_in > 1700;
		rv_below_out = sense_mv_in < -300;
		rv_above_out = sense_mv_in > -100;
		supply_ok_out = vcc_mv_in > LOCKOUT_MV;
		tt_gnd_out = tt_mv_in < GROUND_MV;
		tt_trip_out = 2 * tt_mv_in > vcc_mv_in + 100;
		tt_release_out = 2 * tt_mv_in < vcc_mv_in - 100;
	end
endmodule

// ==== tb/vrpf_top_checker.sv ====
`timescale 1ns/1ps

module vrpf_top_checker (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic enable_in,
	input wire logic supply_ok_cmp_in,
	input wire logic thermal_grounded_cmp_in,
	input wire logic reverse_below_cmp_in,
	input wire logic reverse_above_cmp_in,
	input wire logic [6:0] voltage_select_code_in,
	input wire logic [2:0] phase_pwm_out,
	input wire logic lowside_mode_ctl_out,
	input wire logic driver_enable_out,
	input wire logic softstart_discharge_out,
	input wire logic overvoltage_guard_latched_out,
	input wire logic reverse_voltage_guard_out,
	input wire logic switching_out,
	input wire logic [15:0] voltage_target_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!arst_n_in);
	sequence gnd_held;
		thermal_grounded_cmp_in [*4];
	endsequence
	sequence rv_seen;
		reverse_below_cmp_in [*3];
	endsequence
	chk_crowbar_drive: assert property (
		overvoltage_guard_latched_out && !reverse_voltage_guard_out
		|-> phase_pwm_out == 3'h0 && lowside_mode_ctl_out && driver_enable_out)
		else $error("crowbar drive wrong");
	chk_latch_holds: assert property (
		overvoltage_guard_latched_out && enable_in && supply_ok_cmp_in
		&& $past(supply_ok_cmp_in) && $past(supply_ok_cmp_in, 2) |=> overvoltage_guard_latched_out)
		else $error("latch released early");
	chk_ground_blocks: assert property (
		gnd_held ##0 !overvoltage_guard_latched_out |=> !overvoltage_guard_latched_out)
		else $error("trip while sense grounded");
	chk_reverse_off: assert property (
		reverse_voltage_guard_out
		|-> phase_pwm_out == 3'h0 && !lowside_mode_ctl_out && !driver_enable_out)
		else $error("reverse drive wrong");
	chk_reverse_entry: assert property (
		rv_seen |-> ##[1:2] reverse_voltage_guard_out)
		else $error("reverse not entered");
	chk_reverse_hold: assert property (
		reverse_voltage_guard_out && !reverse_above_cmp_in && !$past(reverse_above_cmp_in)
		&& !$past(reverse_above_cmp_in, 2) |=> reverse_voltage_guard_out)
		else $error("reverse left early");
	chk_shutdown_drive: assert property (
		!enable_in |=> !switching_out && softstart_discharge_out && phase_pwm_out == 3'h0
		&& !lowside_mode_ctl_out && !driver_enable_out)
		else $error("shutdown drive wrong");
	chk_target_decode: assert property (
		1'b1 |=> voltage_target_out == (($past(voltage_select_code_in) >= 7'h78) ? 16'h0000
		: 16'h3A98 - 16'h007D * $past(voltage_select_code_in)))
		else $error("target decode wrong");
endmodule

bind vrpf_top vrpf_top_checker u_vrpf_top_checker (.clock_in, .arst_n_in, .enable_in,
	.supply_ok_cmp_in, .thermal_grounded_cmp_in, .reverse_below_cmp_in, .reverse_above_cmp_in,
	.voltage_select_code_in, .phase_pwm_out, .lowside_mode_ctl_out, .driver_enable_out,
	.softstart_discharge_out, .overvoltage_guard_latched_out, .reverse_voltage_guard_out,
	.switching_out, .voltage_target_out);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "vrpf_defines.svh"

module tb;
	// Every input starts at ground before the supply comes up.
	logic clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic enable_in = 1'b0;
	logic [2:0] phase_pwm_req_in = 3'h0;
	logic [7:0] inductor_current_in = 8'h00;
	logic [6:0] voltage_select_code_in = 7'h00;
	int sense_mv = 0;
	int tt_mv = 0;
	int vcc_mv = 0;
	int fails = 0;
	int checks_done = 0;
	logic overvoltage_cmp_in, reverse_below_cmp_in, reverse_above_cmp_in, supply_ok_cmp_in;
	logic thermal_grounded_cmp_in, thermal_trip_cmp_in, thermal_release_cmp_in;
	// The bench only reads the outputs; after reset they show the shutdown drive while supply is off.
	logic [2:0] phase_pwm_out;
	logic lowside_mode_ctl_out, driver_enable_out, softstart_discharge_out;
	logic thermal_throttle_alarm_out, power_monitor_out, overvoltage_guard_latched_out;
	logic reverse_voltage_guard_out, switching_out;
	logic [15:0] voltage_target_out;
	wire [6:0] st = {phase_pwm_out, softstart_discharge_out, overvoltage_guard_latched_out,
		reverse_voltage_guard_out, switching_out};
	wire [1:0] dr = {lowside_mode_ctl_out, driver_enable_out};

	vrpf_top u_vrpf_top (.clock_in, .arst_n_in, .enable_in, .overvoltage_cmp_in,
		.reverse_below_cmp_in, .reverse_above_cmp_in, .supply_ok_cmp_in,
		.thermal_grounded_cmp_in, .thermal_trip_cmp_in, .thermal_release_cmp_in,
		.phase_pwm_req_in, .inductor_current_in, .voltage_select_code_in, .phase_pwm_out,
		.lowside_mode_ctl_out, .driver_enable_out, .softstart_discharge_out,
		.thermal_throttle_alarm_out, .power_monitor_out, .voltage_target_out,
		.overvoltage_guard_latched_out, .reverse_voltage_guard_out, .switching_out);
	vrpf_supply_model u_vrpf_supply_model (.sense_mv_in(sense_mv), .tt_mv_in(tt_mv),
		.vcc_mv_in(vcc_mv), .ov_out(overvoltage_cmp_in), .rv_below_out(reverse_below_cmp_in),
		.rv_above_out(reverse_above_cmp_in), .supply_ok_out(supply_ok_cmp_in),
		.tt_gnd_out(thermal_grounded_cmp_in), .tt_trip_out(thermal_trip_cmp_in),
		.tt_release_out(thermal_release_cmp_in));

	always #5 clock_in = ~clock_in;

	task end_of_test;
		if (fails == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	// Leaves room for the two synchroniser stages and the state update.
	task drv(input int mv);
		@(posedge clock_in) sense_mv <= mv;
		cyc(5);
	endtask
	task wt(input logic v, output int n);
		n = 0;
		while (power_monitor_out !== v) begin
			cyc(1);
			n++;
			if (n > 1000) begin
				fails++;
				end_of_test;
			end
		end
	endtask
	task t_start;
		@(posedge clock_in) vcc_mv <= 5000;
		tt_mv <= 2000;
		sense_mv <= 1200;
		phase_pwm_req_in <= 3'h5;
		cyc(5);
		chk(st, 7'h08);
		chk(dr, 2'h0);
		@(posedge clock_in) enable_in <= 1'b1;
		cyc(1);
		chk(st, 7'h51);
	endtask
	task t_ov;
		drv(1800);
		chk(st, 7'h04);
		chk(dr, 2'h3);
		drv(-400);
		chk(st, 7'h06);
		chk(dr, 2'h0);
		drv(-200);
		chk(st, 7'h06);
		drv(0);
		chk(dr, 2'h3);
		drv(1200);
		chk(st, 7'h04);
		@(posedge clock_in) enable_in <= 1'b0;
		@(posedge clock_in) enable_in <= 1'b1;
		cyc(1);
		chk(st, 7'h51);
	endtask
	task t_gnd;
		@(posedge clock_in) tt_mv <= 0;
		drv(1800);
		chk(st, 7'h51);
		drv(1200);
		@(posedge clock_in) tt_mv <= 2000;
	endtask
	task t_rev;
		@(posedge clock_in) sense_mv <= -400;
		cyc(2);
		chk(st, 7'h51);
		cyc(1);
		chk(st, 7'h03);
		chk(dr, 2'h0);
		drv(-200);
		chk(st, 7'h03);
		drv(1200);
		chk(st, 7'h51);
	endtask
	task t_sup;
		@(posedge clock_in) vcc_mv <= 3000;
		cyc(5);
		chk(st, 7'h08);
		chk(dr, 2'h0);
		@(posedge clock_in) vcc_mv <= 5000;
		cyc(5);
		chk(st, 7'h51);
	endtask
	task t_therm;
		int tv[4] = '{2600, 2500, 2400, 2500};
		logic [3:0] ex = 4'h3;
		foreach (tv[i]) begin
			@(posedge clock_in) tt_mv <= tv[i];
			cyc(5);
			chk(thermal_throttle_alarm_out, ex[i]);
		end
	endtask
	task t_vid;
		logic [6:0] cv[6] = '{7'h00, 7'h01, 7'h40, 7'h77, 7'h78, 7'h7F};
		logic [15:0] ev;
		foreach (cv[i]) begin
			@(posedge clock_in) voltage_select_code_in <= cv[i];
			cyc(2);
			ev = (cv[i] >= 7'h78) ? 16'h0000 : 16'h3A98 - 16'h007D * cv[i];
			chk(voltage_target_out, ev);
		end
	endtask
	task t_power_monitor_out;
		int hi;
		int lo;
		@(posedge clock_in) inductor_current_in <= 8'h80;
		wt(1'b0, lo);
		wt(1'b1, lo);
		wt(1'b0, hi);
		wt(1'b1, lo);
		chk(16'(hi), 16'h00A6);
		chk(16'(hi + lo), 16'(`VRPF_POWER_MONITOR_OUT_CYC));
	endtask

	initial begin
		cyc(2);
		chk(st, 7'h08);
		@(posedge clock_in) arst_n_in <= 1'b1;
		t_start;
		t_ov;
		t_gnd;
		t_rev;
		t_sup;
		t_therm;
		t_vid;
		t_power_monitor_out;
		end_of_test;
	end
endmodule
